//--- design/bemf_stall_detector.v
// Back-EMF stall detector with APB registers and interrupt
//
// Behaviour
// R1 - Summary stall is the OR of low delta, high delta and absolute flags
// R2 - Low delta flag sets when sample is below average minus delta
// R3 - High delta flag sets when sample is above average plus delta
// R4 - Absolute flag sets when sample is below the absolute level
// R5 - A stall that stops the motor also sets the lost-step flag
// R6 - Settle code and chop rate select the measurement delay
// R7 - Host picks largest settle code shorter than one full step
// R8 - Blanking code n suppresses evaluation for n full steps after accel
// R9 - Absolute code zero disables; else level is code times 0.5 V
// R10 - Delta code zero disables; else difference is code times 0.25 V
// R11 - With full-duty mask set, detection is masked at 100% duty
// R12 - Host enables the mask near full duty and avoids such speeds
// R13 - Host keeps chop jitter off while stall detection is used
// R14 - Move command refused while lost-step or any fault flag is set
// R15 - Stall flags stay latched until the host reads them
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "stall_map.vh"
module bemf_stall_detector #(
    parameter CYCLES_PER_US = `CLK_MHZ,
    parameter AVG_SHIFT     = 3
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst_n,
    // APB slave
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    // Back-EMF measurement, 62.5 mV per step
    input  wire          bemf_valid,
    input  wire [7:0]    bemf_sample,
    // Motion events
    input  wire          full_step,
    input  wire          accel_done,
    input  wire          duty_full,
    input  wire          move_to_target_cmd,
    // Fault pins
    input  wire          thermal_shutdown_flag,
    input  wire          undervoltage_flag,
    input  wire          electrical_defect_flag,
    // Results
    output reg           stall_r,
    output reg           motor_stop_r,
    output reg           move_start_r,
    output reg           chop_rate_select_r,
    output reg           chop_jitter_enable_r,
    output reg           irq_r
);
    // Configuration and status state
    reg  [`CFG_WIDTH-1:0] cfg_r;
    reg                   low_side_delta_flag_r;
    reg                   high_side_delta_flag_r;
    reg                   absolute_level_flag_r;
    reg                   lost_step_flag_r;
    reg  [`IRQ_WIDTH-1:0] irq_status_r;
    reg  [`IRQ_WIDTH-1:0] irq_mask_r;
    reg  [7:0]            sample_r;
    reg  [2:0]            blank_cnt_r;
    reg  [2:0]            blank_cnt_nxt;
    reg                   step_blank_r;

    // Fault synchronisers
    reg  [2:0]            flt_s1_r;
    reg  [2:0]            flt_s2_r;
    reg  [2:0]            flt_s3_r;
    reg  [2:0]            flt_r;

    // Configuration fields
    wire [2:0] settle_window_code =
        cfg_r[`CFG_SETTLE_LSB+2:`CFG_SETTLE_LSB];
    wire [2:0] blanking_full_steps =
        cfg_r[`CFG_BLANK_LSB+2:`CFG_BLANK_LSB];
    wire [3:0] absolute_threshold_code =
        cfg_r[`CFG_ABS_LSB+3:`CFG_ABS_LSB];
    wire [3:0] delta_threshold_code =
        cfg_r[`CFG_DEL_LSB+3:`CFG_DEL_LSB];
    wire       full_duty_mask = cfg_r[`CFG_MASK_BIT];

    // APB decode
    wire       acc_phase = psel & penable & pready;
    wire       wr_en     = acc_phase & pwrite;
    wire       rd_en     = acc_phase & ~pwrite;
    wire       hit_cfg   = paddr == `OFS_CONFIG;
    wire       hit_flags = paddr == `OFS_FLAGS;
    wire       hit_ists  = paddr == `OFS_IRQ_STATUS;
    wire       hit_imask = paddr == `OFS_IRQ_MASK;
    wire       hit_level = paddr == `OFS_LEVEL;
    wire       mapped    = hit_cfg | hit_flags | hit_ists | hit_imask |
                           hit_level;

    // Measurement timing and average
    wire       eval_pt;
    wire [7:0] bemf_avg;

    settle_timer #(
        .CYCLES_PER_US (CYCLES_PER_US),
        .CW            (24)
    ) u_settle (
        .clk   (clk),
        .rst_n (rst_n),
        .start (full_step),
        .code  (settle_window_code),        // see R6
        .rate  (chop_rate_select_r),
        .done  (eval_pt)
    );

    bemf_averager #(
        .W     (8),
        .SHIFT (AVG_SHIFT)
    ) u_avg (
        .clk          (clk),
        .rst_n        (rst_n),
        .sample_valid (eval_pt),
        .sample       (sample_r),
        .average      (bemf_avg)
    );

    // Thresholds in sample steps
    wire [8:0] abs_level = {2'h0, absolute_threshold_code, 3'h0}; // see R9
    wire [8:0] del_level = {3'h0, delta_threshold_code, 2'h0};    // see R10
    wire [8:0] smp9      = {1'b0, sample_r};
    wire [8:0] avg9      = {1'b0, bemf_avg};

    // Evaluation gate: blanking and full-duty masking
    wire       blanked   = step_blank_r;                          // see R8
    wire       duty_mask = full_duty_mask & duty_full;            // see R11
    wire       evaluate  = eval_pt & ~blanked & ~duty_mask;

    wire       hit_lo  = evaluate & (delta_threshold_code != 4'h0) &
                         (smp9 + del_level < avg9);               // see R2
    wire       hit_hi  = evaluate & (delta_threshold_code != 4'h0) &
                         (smp9 > avg9 + del_level);               // see R3
    wire       hit_abs = evaluate & (absolute_threshold_code != 4'h0) &
                         (smp9 < abs_level);                      // see R4
    wire       hit_any = hit_lo | hit_hi | hit_abs;

    // Move gating against lost step and faults
    wire       move_block = lost_step_flag_r | (|flt_r);          // see R14
    wire       move_ok    = move_to_target_cmd & ~move_block;
    wire       move_nak   = move_to_target_cmd & move_block;

    wire       flags_read = rd_en & hit_flags;
    localparam IRQ_W = `IRQ_WIDTH;
    wire [IRQ_W-1:0] irq_set;

    // Clear on read drops only the bits that the read returned
    wire       clr_lo   = flags_read & prdata[`FLG_LO_BIT];
    wire       clr_hi   = flags_read & prdata[`FLG_HI_BIT];
    wire       clr_abs  = flags_read & prdata[`FLG_ABS_BIT];
    wire       clr_lost = flags_read & prdata[`FLG_LOST_BIT];

    assign irq_set = {move_nak, hit_any};

    // Latest measurement
    always @(posedge clk) begin
        if (!rst_n)
            sample_r <= 8'h00;
        else if (bemf_valid)
            sample_r <= bemf_sample;
    end

    // Fault pins: three stages, change taken when stages two and three agree
    always @(posedge clk) begin
        if (!rst_n) begin
            flt_s1_r <= 3'h0;
            flt_s2_r <= 3'h0;
            flt_s3_r <= 3'h0;
            flt_r    <= 3'h0;
        end else begin
            flt_s1_r <= {electrical_defect_flag, undervoltage_flag,
                         thermal_shutdown_flag};
            flt_s2_r <= flt_s1_r;
            flt_s3_r <= flt_s2_r;
            flt_r    <= flt_r ^ ((flt_s2_r ^ flt_r) & ~(flt_s2_r ^ flt_s3_r));
        end
    end

    // Blanking counter loaded after acceleration, counts full steps down
    always @* begin
        blank_cnt_nxt = blank_cnt_r;
        if (accel_done)
            blank_cnt_nxt = blanking_full_steps;                  // see R8
        else if (full_step && blank_cnt_r != 3'h0)
            blank_cnt_nxt = blank_cnt_r - 3'h1;
    end

    always @(posedge clk) begin
        if (!rst_n)
            blank_cnt_r <= 3'h0;
        else
            blank_cnt_r <= blank_cnt_nxt;
    end

    // A step taken while steps remain to be blanked is not evaluated
    always @(posedge clk) begin
        if (!rst_n)
            step_blank_r <= 1'b0;
        else if (full_step)
            step_blank_r <= blank_cnt_r != 3'h0;                  // see R8
    end

    // Sticky stall flags; a new hit wins over the clearing read
    always @(posedge clk) begin
        if (!rst_n) begin
            low_side_delta_flag_r  <= 1'b0;
            high_side_delta_flag_r <= 1'b0;
            absolute_level_flag_r  <= 1'b0;
            lost_step_flag_r       <= 1'b0;
            stall_r                <= 1'b0;
        end else begin
            low_side_delta_flag_r  <= hit_lo |
                (low_side_delta_flag_r & ~clr_lo);                // see R15
            high_side_delta_flag_r <= hit_hi |
                (high_side_delta_flag_r & ~clr_hi);               // see R15
            absolute_level_flag_r  <= hit_abs |
                (absolute_level_flag_r & ~clr_abs);               // see R15
            lost_step_flag_r       <= hit_any |
                (lost_step_flag_r & ~clr_lost);                   // see R5
            stall_r                <= hit_any |
                (low_side_delta_flag_r & ~clr_lo) |
                (high_side_delta_flag_r & ~clr_hi) |
                (absolute_level_flag_r & ~clr_abs);               // see R1
        end
    end

    // Motion outputs
    always @(posedge clk) begin
        if (!rst_n) begin
            motor_stop_r <= 1'b0;
            move_start_r <= 1'b0;
        end else begin
            motor_stop_r <= hit_any;                              // see R5
            move_start_r <= move_ok;                              // see R14
        end
    end

    // Configuration register
    always @(posedge clk) begin
        if (!rst_n) begin
            cfg_r                <= `CFG_RESET;
            chop_rate_select_r   <= 1'b0;
            chop_jitter_enable_r <= 1'b0;
        end else begin
            if (wr_en && hit_cfg)
                cfg_r <= pwdata[`CFG_WIDTH-1:0];
            chop_rate_select_r   <= cfg_r[`CFG_RATE_BIT];
            chop_jitter_enable_r <= cfg_r[`CFG_JITTER_BIT];
        end
    end

    // Interrupt status, mask and output; set wins over write-one clear
    always @(posedge clk) begin
        if (!rst_n) begin
            irq_status_r <= `IRQ_RESET;
            irq_mask_r   <= `IRQ_RESET;
            irq_r        <= 1'b0;
        end else begin
            if (wr_en && hit_ists)
                irq_status_r <= irq_set |
                    (irq_status_r & ~pwdata[IRQ_W-1:0]);
            else
                irq_status_r <= irq_set | irq_status_r;
            if (wr_en && hit_imask)
                irq_mask_r <= pwdata[IRQ_W-1:0];
            irq_r <= |(irq_status_r & irq_mask_r);
        end
    end

    // APB answer: one wait state, error on unmapped offsets
    always @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata  <= 32'h00000000;
            if (psel && penable && !pready && !pwrite) begin
                if (hit_cfg)
                    prdata <= {{(32-`CFG_WIDTH){1'b0}}, cfg_r};
                else if (hit_flags)
                    prdata <= {27'h0000000, lost_step_flag_r, stall_r,
                               absolute_level_flag_r,
                               high_side_delta_flag_r,
                               low_side_delta_flag_r};
                else if (hit_ists)
                    prdata <= {{(32-IRQ_W){1'b0}}, irq_status_r};
                else if (hit_imask)
                    prdata <= {{(32-IRQ_W){1'b0}}, irq_mask_r};
                else if (hit_level)
                    prdata <= {13'h0000, blank_cnt_r, bemf_avg, sample_r};
            end
        end
    end
endmodule
`default_nettype wire

//--- design/stall_map.vh
// Register map, field layout, reset values and timing figures
`ifndef STALL_MAP_VH
`define STALL_MAP_VH

// Register byte offsets
`define OFS_CONFIG      12'h000
`define OFS_FLAGS       12'h004
`define OFS_IRQ_STATUS  12'h008
`define OFS_IRQ_MASK    12'h00c
`define OFS_LEVEL       12'h010

// Configuration fields
`define CFG_SETTLE_LSB  0
`define CFG_BLANK_LSB   3
`define CFG_ABS_LSB     6
`define CFG_DEL_LSB     10
`define CFG_MASK_BIT    14
`define CFG_RATE_BIT    15
`define CFG_JITTER_BIT  16
`define CFG_WIDTH       17
`define CFG_RESET       17'h00000

// Flag register bits
`define FLG_LO_BIT      0
`define FLG_HI_BIT      1
`define FLG_ABS_BIT     2
`define FLG_STALL_BIT   3
`define FLG_LOST_BIT    4

// Interrupt bits
`define IRQ_STALL_BIT   0
`define IRQ_REFUSE_BIT  1
`define IRQ_WIDTH       2
`define IRQ_RESET       2'h0

// Level scaling: one sample step is 62.5 mV
`define ABS_STEP_LSB    8
`define DEL_STEP_LSB    4

// Settle delay in microseconds, low and high chop rate
`define SETTLE_LO_US_0  10'h057
`define SETTLE_LO_US_1  10'h082
`define SETTLE_LO_US_2  10'h0ae
`define SETTLE_LO_US_3  10'h0d9
`define SETTLE_LO_US_4  10'h105
`define SETTLE_LO_US_5  10'h130
`define SETTLE_LO_US_6  10'h15c
`define SETTLE_LO_US_7  10'h187
`define SETTLE_HI_US_0  10'h02b
`define SETTLE_HI_US_1  10'h041
`define SETTLE_HI_US_2  10'h057
`define SETTLE_HI_US_3  10'h06d
`define SETTLE_HI_US_4  10'h082
`define SETTLE_HI_US_5  10'h098
`define SETTLE_HI_US_6  10'h0ae
`define SETTLE_HI_US_7  10'h0c4

// Clock rate in MHz
`define CLK_MHZ         250

`endif

//--- design/settle_timer.v
// Measurement delay timer started on each full step
`timescale 1ns/100ps
`default_nettype none
`include "stall_map.vh"
module settle_timer #(
    parameter CYCLES_PER_US = `CLK_MHZ,
    parameter CW            = 24
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst_n,
    // Control
    input  wire          start,
    input  wire [2:0]    code,
    input  wire          rate,
    // Result
    output reg           done
);
    reg  [CW-1:0] cnt_r;
    reg           run_r;
    reg  [9:0]    us;
    wire [31:0]   load_w = us * CYCLES_PER_US;
    wire [CW-1:0] load   = load_w[CW-1:0];

    always @* begin
        case ({rate, code})
            4'h0:    us = `SETTLE_LO_US_0;
            4'h1:    us = `SETTLE_LO_US_1;
            4'h2:    us = `SETTLE_LO_US_2;
            4'h3:    us = `SETTLE_LO_US_3;
            4'h4:    us = `SETTLE_LO_US_4;
            4'h5:    us = `SETTLE_LO_US_5;
            4'h6:    us = `SETTLE_LO_US_6;
            4'h7:    us = `SETTLE_LO_US_7;
            4'h8:    us = `SETTLE_HI_US_0;
            4'h9:    us = `SETTLE_HI_US_1;
            4'ha:    us = `SETTLE_HI_US_2;
            4'hb:    us = `SETTLE_HI_US_3;
            4'hc:    us = `SETTLE_HI_US_4;
            4'hd:    us = `SETTLE_HI_US_5;
            4'he:    us = `SETTLE_HI_US_6;
            default: us = `SETTLE_HI_US_7;
        endcase
    end

    // Restart on every step; done pulses once the delay has run out
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= {CW{1'b0}};
            run_r <= 1'b0;
            done  <= 1'b0;
        end else if (start) begin
            cnt_r <= load - 1'b1;
            run_r <= 1'b1;
            done  <= 1'b0;
        end else if (run_r && cnt_r == {CW{1'b0}}) begin
            run_r <= 1'b0;
            done  <= 1'b1;
        end else begin
            cnt_r <= run_r ? cnt_r - 1'b1 : cnt_r;
            done  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- design/bemf_averager.v
// Running average of the back-EMF samples
`timescale 1ns/100ps
`default_nettype none
module bemf_averager #(
    parameter W     = 8,
    parameter SHIFT = 3
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst_n,
    // Samples
    input  wire          sample_valid,
    input  wire [W-1:0]  sample,
    // Average
    output wire [W-1:0]  average
);
    reg  [W+SHIFT-1:0] acc_r;
    wire [W+SHIFT-1:0] ext = {{SHIFT{1'b0}}, sample};
    wire [W+SHIFT-1:0] cur = {{SHIFT{1'b0}}, acc_r[W+SHIFT-1:SHIFT]};

    // acc holds average scaled by 2^SHIFT
    always @(posedge clk) begin
        if (!rst_n)
            acc_r <= {(W+SHIFT){1'b0}};
        else if (sample_valid)
            acc_r <= acc_r - cur + ext;
    end

    assign average = acc_r[W+SHIFT-1:SHIFT];
endmodule
`default_nettype wire

//--- verif/bemf_stall_detector_chk.sv
// Port assertions for the stall detector
`timescale 1ns/100ps
`default_nettype none
module bemf_stall_detector_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Motion and faults
    input wire logic        move_to_target_cmd,
    input wire logic        thermal_shutdown_flag,
    input wire logic        undervoltage_flag,
    input wire logic        electrical_defect_flag,
    // Results
    input wire logic        stall_r,
    input wire logic        motor_stop_r,
    input wire logic        move_start_r,
    input wire logic        chop_rate_select_r,
    input wire logic        chop_jitter_enable_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire acc = psel && penable && pready;
    wire rd_flags = acc && !pwrite && paddr == 12'h004;
    wire wr_cfg = acc && pwrite && paddr == 12'h000;
    wire fault = thermal_shutdown_flag || undervoltage_flag ||
                 electrical_defect_flag;
    ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready not a one cycle access answer");
    ready_time_a: assert property (psel && penable && !$past(penable)
        |=> pready) else $error("pready late");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    stop_pulse_a: assert property (motor_stop_r |=> !motor_stop_r)
        else $error("stop pulse too long");
    stop_stall_a: assert property (motor_stop_r |-> ##[0:1] stall_r)
        else $error("stop without summary stall");
    stall_hold_a: assert property ($fell(stall_r) |->
        $past(rd_flags) || $past(rd_flags, 2))
        else $error("stall dropped without a read");
    move_block_a: assert property (fault [*6] ##1 fault &&
        move_to_target_cmd |=> !move_start_r)
        else $error("move started during fault");
    cfg_copy_a: assert property (wr_cfg |-> ##2
        chop_rate_select_r == $past(pwdata[15], 2) &&
        chop_jitter_enable_r == $past(pwdata[16], 2))
        else $error("chop copies wrong");
    cover property (motor_stop_r);
    cover property (pslverr);
    cover property (move_start_r);
endmodule
`default_nettype wire

//--- verif/bemf_source.sv
// Back-EMF measurement model: one sample per full step
`timescale 1ns/100ps
`default_nettype none
module bemf_source (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Control from the bench
    input  wire logic       full_step,
    input  wire logic [7:0] level,
    input  wire logic [3:0] lat,
    // Measurement
    output var  logic       bemf_valid,
    output var  logic [7:0] bemf_sample
);
    logic [4:0] cnt_r;
    always @(posedge clk) begin
        bemf_valid <= 1'b0;
        bemf_sample <= ~bemf_sample;
        if (!rst_n) begin
            cnt_r <= 5'h1f;
            bemf_sample <= 8'h0;
        end else if (full_step) begin
            cnt_r <= {1'b0, lat};
        end else if (cnt_r == 5'h0) begin
            bemf_valid <= 1'b1;
            bemf_sample <= level;
            cnt_r <= 5'h1f;
        end else if (cnt_r != 5'h1f) begin
            cnt_r <= cnt_r - 5'h1;
        end
    end
endmodule
`default_nettype wire

//--- verif/bemf_stall_detector_tb_top.sv
// Self-checking bench for the stall detector
`timescale 1ns/100ps
`default_nettype none
module bemf_stall_detector_tb_top;
    logic        clk, rst_n, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, seed;
    logic        full_step, accel_done, duty_full, move_cmd;
    logic [2:0]  flt;
    logic [7:0]  level;
    logic [3:0]  lat;
    wire  [31:0] prdata;
    wire         pready, pslverr, bemf_valid, stall_r, motor_stop_r;
    wire         move_start_r, rate_r, jit_r, irq_r;
    wire  [7:0]  bemf_sample;
    int          errors, n_checks;
    int          dly_t[16] = '{87, 130, 174, 217, 261, 304, 348, 391,
                               43, 65, 87, 109, 130, 152, 174, 196};
    bemf_stall_detector #(.CYCLES_PER_US(1)) bemf_stall_detector_inst (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bemf_valid(bemf_valid),
        .bemf_sample(bemf_sample), .full_step(full_step),
        .accel_done(accel_done), .duty_full(duty_full),
        .move_to_target_cmd(move_cmd), .thermal_shutdown_flag(flt[0]),
        .undervoltage_flag(flt[1]), .electrical_defect_flag(flt[2]),
        .stall_r(stall_r), .motor_stop_r(motor_stop_r),
        .move_start_r(move_start_r), .chop_rate_select_r(rate_r),
        .chop_jitter_enable_r(jit_r), .irq_r(irq_r));
    bemf_source bemf_source_inst (.clk(clk), .rst_n(rst_n),
        .full_step(full_step), .level(level), .lat(lat),
        .bemf_valid(bemf_valid), .bemf_sample(bemf_sample));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic test_done();
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            errors++;
            $display("BAD %0t apb timeout", $time);
            test_done();
        end
    endtask
    task automatic rst();
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic step_eval(input int n, input logic e);
        logic s;
        s = 1'b0;
        @(posedge clk);
        full_step <= 1'b1;
        @(posedge clk);
        full_step <= 1'b0;
        for (int c = 1; c <= n + 6; c++) begin
            @(posedge clk);
            if (motor_stop_r === 1'b1 && s !== 1'bx) s = c >= n ? 1'b1 : 1'bx;
        end
        chk({31'h0, s}, {31'h0, e});
    endtask
    task automatic mv(input logic e);
        @(posedge clk);
        move_cmd <= 1'b1;
        @(posedge clk);
        move_cmd <= 1'b0;
        @(posedge clk);
        chk({31'h0, move_start_r}, {31'h0, e});
    endtask
    function automatic logic [31:0] cfg(input logic [3:0] a, d,
        input logic [2:0] b, c, input logic m, r);
        return {16'h0, r, m, d, a, b, c}; // jitter off
    endfunction
    function automatic logic [31:0] exp_flags(input logic [7:0] s,
                                              input logic [3:0] a, d);
        logic hi, ab;
        hi = d != 4'h0 && s > {d, 2'b00};
        ab = a != 4'h0 && s < {a, 3'b000};
        return {27'h0, hi | ab, hi | ab, ab, hi, 1'b0};
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rst_n, level, lat} = '0;
        {full_step, accel_done, duty_full, move_cmd, flt} = '0;
        errors = 0;
        n_checks = 0;
        seed = 32'h710ce65d;
        rst();
        for (int a = 0; a < 6; a++) begin
            apb(1'b0, 12'(a * 4), 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, err}, {31'h0, a == 5});
        end
        apb(1'b1, 12'h000, 32'h8000);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h8000);
        chk({30'h0, jit_r, rate_r}, 32'h1);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, 12'h000, cfg(4'hf, 4'h0, 3'h0, i[2:0], 1'b0, i[3]));
            step_eval(dly_t[i], 1'b1);
        end
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 12'h00c, 32'h3);
        repeat (2) @(posedge clk);
        chk({31'h0, irq_r}, 32'h1);
        apb(1'b1, 12'h008, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq_r}, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h1c);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, stall_r}, 32'h0);
        for (int m = 0; m < 3; m++) begin
            duty_full <= m != 2;
            apb(1'b1, 12'h000, cfg(4'hf, 4'h0, 3'h0, 3'h0, m != 1, 1'b1));
            step_eval(43, m != 0);
        end
        duty_full <= 1'b0;
        for (int n = 1; n < 8; n += 6) begin
            apb(1'b1, 12'h000, cfg(4'hf, 4'h0, n[2:0], 3'h0, 1'b0, 1'b1));
            @(posedge clk);
            accel_done <= 1'b1;
            @(posedge clk);
            accel_done <= 1'b0;
            for (int k = 1; k <= n + 1; k++) step_eval(43, k == n + 1);
        end
        apb(1'b0, 12'h004, 32'h0);
        mv(1'b1);
        step_eval(43, 1'b1);
        mv(1'b0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd & 32'h2, 32'h2);
        apb(1'b0, 12'h004, 32'h0);
        for (int f = 0; f < 3; f++) begin
            flt <= 3'(1 << f);
            repeat (8) @(posedge clk);
            mv(1'b0);
            flt <= 3'h0;
            repeat (8) @(posedge clk);
        end
        mv(1'b1);
        for (int i = 0; i < 24; i++) begin
            logic [3:0]  a, d;
            logic [7:0]  s;
            logic [31:0] e;
            seed = xs(seed);
            {d, a, s} = seed[15:0];
            if (i == 0) {a, s} = {4'h9, 8'h48};
            if (i == 1) {a, s} = {4'h9, 8'h47};
            if (i == 2) {d, s} = {4'h5, 8'h14};
            e = exp_flags(s, a, d);
            rst();
            lat <= seed[19:16];
            level <= s;
            apb(1'b1, 12'h000, cfg(a, d, 3'h0, 3'h0, 1'b0, 1'b1));
            step_eval(43, e[3]);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd, e);
        end
        rst();
        level <= 8'hff;
        apb(1'b1, 12'h000, cfg(4'h0, 4'h0, 3'h0, 3'h0, 1'b0, 1'b1));
        repeat (24) step_eval(43, 1'b0);
        apb(1'b1, 12'h000, cfg(4'h0, 4'h1, 3'h0, 3'h0, 1'b0, 1'b1));
        level <= 8'h0;
        step_eval(43, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h19);
        test_done();
    end
endmodule
bind bemf_stall_detector bemf_stall_detector_chk bemf_stall_detector_chk_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .move_to_target_cmd(move_to_target_cmd),
    .thermal_shutdown_flag(thermal_shutdown_flag),
    .undervoltage_flag(undervoltage_flag),
    .electrical_defect_flag(electrical_defect_flag),
    .stall_r(stall_r), .motor_stop_r(motor_stop_r),
    .move_start_r(move_start_r), .chop_rate_select_r(chop_rate_select_r),
    .chop_jitter_enable_r(chop_jitter_enable_r));
`default_nettype wire
